// *** ctu_consts.svh ***
// constants for the conditional transfer unit
`ifndef CTU_CONSTS_SVH
`define CTU_CONSTS_SVH
// instruction word positions, bit s = msb (index 35 in vector)
`define CTU_OP_HI        35
`define CTU_OP_LO        33
`define CTU_DEC_HI       32
`define CTU_DEC_LO       18
`define CTU_TAG_HI       17
`define CTU_TAG_LO       15
`define CTU_ADR_HI       14
`define CTU_ADR_LO       0
// accumulator sign position, magnitude sits below it
`define CTU_ACC_SIGN     35
// offset bit that selects the index register window
`define CTU_A_XSEL       3
// operation codes
`define CTU_OP_XGT       3'h0
`define CTU_OP_XLE       3'h1
`define CTU_OP_MGT       3'h2
`define CTU_OP_MLE       3'h3
`define CTU_OP_AMI       3'h4
`define CTU_OP_APL       3'h5
`define CTU_OP_ANZ       3'h6
`define CTU_OP_AZE       3'h7
// secondary condition select for overflow test
`define CTU_OVF_SEL      1'h1
// register bus offsets
`define CTU_A_CTRL       4'h0
`define CTU_A_INSTR      4'h1
`define CTU_A_ACC        4'h2
`define CTU_A_IC         4'h3
`define CTU_A_AR         4'h4
`define CTU_A_STAT       4'h5
`define CTU_A_XR0        4'h8
// control and status bits
`define CTU_C_GO         0
`define CTU_C_OVFSEL     1
`define CTU_C_SETOVF     2
`define CTU_STAT_BUSY    0
`define CTU_STAT_TAKEN   1
`define CTU_STAT_OVF     2
`define CTU_STAT_XC      3
`endif

// *** ctu_pkg.sv ***
// types for the conditional transfer unit
package ctu_pkg;
	typedef enum logic [2:0] {
		CTU_IDLE  = 3'h0,
		CTU_ADDR  = 3'h1,
		CTU_TEST  = 3'h3,
		CTU_XWR1  = 3'h2,
		CTU_XWR2  = 3'h6,
		CTU_XFER  = 3'h7,
		CTU_NEXT  = 3'h5
	} ctu_state_t;
endpackage

// *** ctu_adder.sv ***
// 15-bit adder for positions 21 to 35 with carry out of 21
module ctu_adder #(
	parameter int W = 15
) (
	// operands
	input  wire logic [W-1:0] a,
	input  wire logic [W-1:0] b,
	input  wire logic         cin,
	// result
	output logic      [W-1:0] sum,
	output logic              cout
);
	// plain unsigned add, carry leaves top position
	assign {cout, sum} = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
endmodule // ctu_adder

// *** ctu_xregs.sv ***
// index register file, registered read port
module ctu_xregs #(
	parameter int W = 15,
	parameter int N = 8
) (
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	// write port
	input  wire logic                 we,
	input  wire logic [$clog2(N)-1:0] waddr,
	input  wire logic [W-1:0]         wdata,
	// read port
	input  wire logic [$clog2(N)-1:0] raddr,
	output logic      [W-1:0]         rdata
);
	localparam int AW = $clog2(N);   // entry select width
	logic [W-1:0] mem [N];   // storage words

	// per-entry write with reset clear
	for (genvar i = 0; i < N; i++) begin : g_ent
		always_ff @(posedge mclk) begin
			if (!rst_n)
				mem[i] <= '0;
			else if (we && waddr == AW'(i))
				mem[i] <= wdata;
		end
	end

	// read data from a flip-flop
	always_ff @(posedge mclk) begin
		if (!rst_n)
			rdata <= '0;
		else
			rdata <= mem[raddr];
	end
endmodule // ctu_xregs

// *** ctu_core.sv ***
// conditional transfer unit: index and accumulator tested transfers
//
// Our own choices: the address map and the plain strobed port.
`include "ctu_consts.svh"
// What this block does
// - index compare: base address unmodified to address register
// - opcode picks greater or equal-or-less test
// - decrement true, index complemented, carry-in one
// - carry out of 21 is compare flag
// - greater variant: flag clear takes transfer
// - equal-or-less variant: flag set takes transfer
// - modify group: tag picks tested, updated register
// - modify greater, clear: store index minus decrement
// - counter loaded after index update completes
// - modify greater, set: no transfer, sequential
// - modify le: set transfers, clear reduces index
// - accumulator tests: sign, zero, nonzero, overflow
// - overflow transfer clears indicator first
// - accumulator group allows indexing of base
// - condition true loads counter, else sequential
// - fields: tag 18-20, decrement 3-17, op s-2
module ctu_core
	import ctu_pkg::*;
#(
	parameter int W = 15,
	parameter int N = 8
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// register port
	input  wire logic [3:0]  addr,
	input  wire logic [35:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [35:0] rdata,
	// status
	output logic             busy,
	output logic      [W-1:0] ic
);
	localparam int XW = $clog2(N);   // index select width

	ctu_state_t   st_q;        // sequencer state
	logic [35:0]  instr_q;     // instruction word
	logic [35:0]  acc_q;       // accumulator s,q,p,1-35 low 36
	logic         ovf_q;       // accumulator overflow indicator
	logic         ovfsel_q;    // op 3'h4 only: use overflow test instead of sign
	logic [W-1:0] ic_q;        // instruction counter
	logic [W-1:0] ar_q;        // address register
	logic         xc_q;        // latched compare flag
	logic         taken_q;     // last op transferred
	logic [W-1:0] diff_q;      // held adder result
	logic [35:0]  rdata_q;     // read data register

	// instruction fields
	logic [2:0]    op;
	logic [W-1:0]  dec;
	logic [XW-1:0] tag;
	logic [W-1:0]  base;
	assign op   = instr_q[`CTU_OP_HI:`CTU_OP_LO];
	assign dec  = instr_q[`CTU_DEC_HI:`CTU_DEC_LO];
	assign tag  = instr_q[`CTU_TAG_LO+XW-1:`CTU_TAG_LO];
	assign base = instr_q[`CTU_ADR_HI:`CTU_ADR_LO];

	// group decode
	logic grp_x, grp_m, grp_a, want_gt;
	assign grp_x   = (op == `CTU_OP_XGT) || (op == `CTU_OP_XLE);
	assign grp_m   = (op == `CTU_OP_MGT) || (op == `CTU_OP_MLE);
	assign grp_a   = op[2];
	assign want_gt = (op == `CTU_OP_XGT) || (op == `CTU_OP_MGT);

	// index register file
	logic          x_we;
	logic [XW-1:0] x_wa;
	logic [W-1:0]  x_wd;
	logic [XW-1:0] x_ra;
	logic [W-1:0]  xr;
	ctu_xregs #(.W(W), .N(N)) u_xr (
		.mclk  (mclk),
		.rst_n (rst_n),
		.we    (x_we),
		.waddr (x_wa),
		.wdata (x_wd),
		.raddr (x_ra),
		.rdata (xr)
	);

	// bus writes to index registers vs sequencer updates
	logic bus_xw;
	assign bus_xw = wr && addr[`CTU_A_XSEL];
	assign x_ra   = tag;
	always_comb begin
		x_we = 1'b0;
		x_wa = tag;
		x_wd = diff_q;
		if (st_q == CTU_XWR1 || st_q == CTU_XWR2) begin
			x_we = 1'b1;
		end else if (bus_xw && st_q == CTU_IDLE) begin
			x_we = 1'b1;
			x_wa = addr[XW-1:0];
			x_wd = wdata[W-1:0];
		end
	end

	// adder input selection
	logic [W-1:0] ad_a, ad_b, ad_s;
	logic         ad_ci, ad_co;
	always_comb begin
		ad_a  = '0;
		ad_b  = '0;
		ad_ci = 1'b0;
		case (st_q)
			CTU_ADDR: begin
				ad_a = base;
				ad_b = grp_a ? xr : '0;
			end
			CTU_TEST: begin
				ad_a  = dec;
				ad_b  = ~xr;
				ad_ci = 1'b1;
			end
			CTU_XWR1: begin
				ad_a  = '0;
				ad_b  = ~diff_q;
				ad_ci = 1'b1;
			end
			default: begin
				ad_a  = '0;
			end
		endcase
	end
	ctu_adder #(.W(W)) u_add (
		.a    (ad_a),
		.b    (ad_b),
		.cin  (ad_ci),
		.sum  (ad_s),
		.cout (ad_co)
	);

	// accumulator condition
	logic acc_neg, acc_mag0, acond;
	assign acc_neg  = acc_q[`CTU_ACC_SIGN];
	assign acc_mag0 = (acc_q[`CTU_ACC_SIGN-1:0] == '0);
	always_comb begin
		case (op)
			`CTU_OP_AMI: acond = ovfsel_q ? ovf_q : acc_neg;
			`CTU_OP_APL: acond = !acc_neg;
			`CTU_OP_ANZ: acond = !acc_mag0;
			`CTU_OP_AZE: acond = acc_mag0;
			default:     acond = 1'b0;
		endcase
	end

	// take decision from flag
	logic xtake;
	assign xtake = want_gt ? !ad_co : ad_co;

	// sequencer
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_q <= CTU_IDLE;
		end else begin
			case (st_q)
				CTU_IDLE: if (wr && addr == `CTU_A_CTRL
					&& wdata[`CTU_C_GO])
					st_q <= CTU_ADDR;
				CTU_ADDR: st_q <= CTU_TEST;
				CTU_TEST: begin
					if (grp_a)
						st_q <= acond ? CTU_XFER : CTU_NEXT;
					else if (grp_x)
						st_q <= xtake ? CTU_XFER : CTU_NEXT;
					else if (grp_m && want_gt)
						st_q <= xtake ? CTU_XWR1 : CTU_NEXT;
					else
						st_q <= xtake ? CTU_XFER : CTU_XWR1;
				end
				CTU_XWR1: st_q <= CTU_XWR2;
				CTU_XWR2: st_q <= want_gt ? CTU_XFER : CTU_NEXT;
				CTU_XFER: st_q <= CTU_IDLE;
				CTU_NEXT: st_q <= CTU_IDLE;
				default:  st_q <= CTU_IDLE;
			endcase
		end
	end

	// address register and held difference
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ar_q   <= '0;
			diff_q <= '0;
			xc_q   <= 1'b0;
		end else begin
			if (st_q == CTU_ADDR)
				ar_q <= ad_s;
			if (st_q == CTU_TEST) begin
				diff_q <= ad_s;
				xc_q   <= ad_co;
			end
			if (st_q == CTU_XWR1)
				diff_q <= ad_s;
		end
	end

	// instruction counter
	always_ff @(posedge mclk) begin
		if (!rst_n)
			ic_q <= '0;
		else if (st_q == CTU_IDLE && wr && addr == `CTU_A_IC)
			ic_q <= wdata[W-1:0];
		else if (st_q == CTU_XFER)
			ic_q <= ar_q;
		else if (st_q == CTU_NEXT)
			ic_q <= ic_q + {{(W-1){1'b0}}, 1'b1};
	end

	// taken flag
	always_ff @(posedge mclk) begin
		if (!rst_n)
			taken_q <= 1'b0;
		else if (st_q == CTU_XFER)
			taken_q <= 1'b1;
		else if (st_q == CTU_NEXT)
			taken_q <= 1'b0;
	end

	// overflow indicator: set by software, cleared on its transfer
	always_ff @(posedge mclk) begin
		if (!rst_n)
			ovf_q <= 1'b0;
		else if (st_q == CTU_TEST && grp_a && ovfsel_q
			&& op == `CTU_OP_AMI && ovf_q)
			ovf_q <= 1'b0;
		else if (st_q == CTU_IDLE && wr && addr == `CTU_A_CTRL
			&& wdata[`CTU_C_SETOVF])
			ovf_q <= 1'b1;
	end

	// instruction, accumulator and select registers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			instr_q  <= '0;
			acc_q    <= '0;
			ovfsel_q <= 1'b0;
		end else if (st_q == CTU_IDLE && wr) begin
			case (addr)
				`CTU_A_INSTR: instr_q <= wdata;
				`CTU_A_ACC:   acc_q   <= wdata;
				`CTU_A_CTRL:  ovfsel_q <= wdata[`CTU_C_OVFSEL];
				default:      ;
			endcase
		end
	end

	// read port, data one cycle later
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else if (rd) begin
			case (addr)
				`CTU_A_CTRL:  rdata_q <= {35'h0, ovfsel_q} << 1;
				`CTU_A_INSTR: rdata_q <= instr_q;
				`CTU_A_ACC:   rdata_q <= acc_q;
				`CTU_A_IC:    rdata_q <= {21'h0, ic_q};
				`CTU_A_AR:    rdata_q <= {21'h0, ar_q};
				`CTU_A_STAT:  rdata_q <= {32'h0, xc_q, ovf_q, taken_q,
					st_q != CTU_IDLE};
				default:      rdata_q <= 36'h0;
			endcase
		end else begin
			rdata_q <= 36'h0;
		end
	end

	assign rdata = rdata_q;
	assign busy  = (st_q != CTU_IDLE);
	assign ic    = ic_q;

	// assertions
	property p_xfer_ic; // loads counter from ar
		@(posedge mclk) disable iff (!rst_n)
		st_q == CTU_XFER |=> ic_q == $past(ar_q);
	endproperty
	a_xfer_ic: assert property (p_xfer_ic) else $error("ic not ar");

	property p_xgrp; // index-only group decision
		@(posedge mclk) disable iff (!rst_n)
		(st_q == CTU_TEST && grp_x) |=>
			(st_q == CTU_XFER) == $past(want_gt ? !ad_co : ad_co);
	endproperty
	a_xgrp: assert property (p_xgrp) else $error("x decision");

	property p_flag; // flag equals unsigned le
		@(posedge mclk) disable iff (!rst_n)
		st_q == CTU_TEST && !grp_a |-> ad_co == (xr <= dec);
	endproperty
	a_flag: assert property (p_flag) else $error("flag wrong");

	sequence s_mgt_clear;
		st_q == CTU_TEST && op == `CTU_OP_MGT && !ad_co;
	endsequence
	property p_mgt; // update then transfer
		@(posedge mclk) disable iff (!rst_n)
		s_mgt_clear |=> st_q == CTU_XWR1 ##1 st_q == CTU_XWR2
			##1 st_q == CTU_XFER;
	endproperty
	a_mgt: assert property (p_mgt) else $error("mgt order");

	property p_mgt_val; // stored value is index minus decrement
		@(posedge mclk) disable iff (!rst_n)
		s_mgt_clear |=> ##1 x_wd == $past(xr, 2) - $past(dec, 2);
	endproperty
	a_mgt_val: assert property (p_mgt_val) else $error("diff");

	property p_mgt_set; // flag set ends sequentially
		@(posedge mclk) disable iff (!rst_n)
		st_q == CTU_TEST && op == `CTU_OP_MGT && ad_co |=>
			st_q == CTU_NEXT;
	endproperty
	a_mgt_set: assert property (p_mgt_set) else $error("mgt set");

	property p_mle; // le modify
		@(posedge mclk) disable iff (!rst_n)
		st_q == CTU_TEST && op == `CTU_OP_MLE |=>
			($past(ad_co) ? st_q == CTU_XFER : st_q == CTU_XWR1);
	endproperty
	a_mle: assert property (p_mle) else $error("mle path");

	property p_ovf; // overflow cleared before transfer
		@(posedge mclk) disable iff (!rst_n)
		st_q == CTU_XFER && op == `CTU_OP_AMI && ovfsel_q |-> !ovf_q;
	endproperty
	a_ovf: assert property (p_ovf) else $error("ovf kept");

	property p_ar; // ar holds base unmodified for index groups
		@(posedge mclk) disable iff (!rst_n)
		st_q == CTU_TEST && !grp_a |-> ar_q == base;
	endproperty
	a_ar: assert property (p_ar) else $error("ar indexed");

	// le modify with flag clear writes index minus decrement back
	property p_mle_val;
		@(posedge mclk) disable iff (!rst_n)
		st_q == CTU_TEST && op == `CTU_OP_MLE && !ad_co |=> ##1
			x_we && x_wd == $past(xr, 2) - $past(dec, 2);
	endproperty
	a_mle_val: assert property (p_mle_val) else $error("le diff");

	// accumulator group adds the tagged index to the base
	property p_aidx;
		@(posedge mclk) disable iff (!rst_n)
		st_q == CTU_ADDR && grp_a |=>
			ar_q == W'($past(base) + $past(xr));
	endproperty
	a_aidx: assert property (p_aidx) else $error("ar not indexed");
endmodule // ctu_core

// *** ctu_tb.sv ***
// self-checking testbench for the conditional transfer unit
`include "ctu_consts.svh"
module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [14:0] BA  = 15'h1234; // base address field
	localparam logic [14:0] IC0 = 15'h0040; // counter before each op

	// clock and reset
	logic        mclk;
	logic        rst_n;
	// register port
	logic [3:0]  addr;
	logic [35:0] wdata;
	logic        wr;
	logic        rd;
	logic [35:0] rdata;
	// status
	logic        busy;
	logic [14:0] ic;
	// bookkeeping
	int          fails;
	int          num_checks;
	logic [35:0] rv;

	ctu_core uut (
		.mclk  (mclk),
		.rst_n (rst_n),
		.addr  (addr),
		.wdata (wdata),
		.wr    (wr),
		.rd    (rd),
		.rdata (rdata),
		.busy  (busy),
		.ic    (ic)
	);

	// free running clock, 8 ns period
	always #4 mclk = ~mclk;

	// compare and count
	task automatic chk(input string nm, input logic [35:0] e,
		input logic [35:0] g);
		num_checks++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask

	// one-cycle write strobe, then one idle edge
	task automatic wr_reg(input logic [3:0] a, input logic [35:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		@(posedge mclk);
	endtask

	// read strobe; data stands in the following cycle only
	task automatic rd_reg(input logic [3:0] a, output logic [35:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		d = rdata;
		@(posedge mclk);
	endtask

	// run one instruction from a known counter and check the outcome
	task automatic do_case(input logic [2:0] o, input logic [14:0] d,
		input logic [2:0] t, input logic [2:0] ctl, input logic tk,
		input logic ov, input logic [14:0] ear, input logic poke);
		int i;
		wr_reg(`CTU_A_IC, {21'h0, IC0});
		wr_reg(`CTU_A_INSTR, {o, d, t, BA});
		wr_reg(`CTU_A_CTRL, {33'h0, ctl | 3'h1});
		chk("busy", 36'h1, {35'h0, busy});
		// a write while busy must not reach the counter
		if (poke)
			wr_reg(`CTU_A_IC, 36'h7777);
		for (i = 0; i < 40 && busy !== 1'b0; i++)
			@(posedge mclk);
		// a sequencer that never idles counts as a mismatch
		chk("idle", 36'h0, {35'h0, busy});
		rd_reg(`CTU_A_STAT, rv);
		chk("stat", {33'h0, ov, tk, 1'b0}, {33'h0, rv[2:0]});
		rd_reg(`CTU_A_AR, rv);
		chk("ar", {21'h0, ear}, rv);
		chk("ic", {21'h0, tk ? ear : IC0 + 15'h1}, {21'h0, ic});
	endtask

	// verdict and end of run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// watchdog against a hung sequencer
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		stop_test();
	end

	// main sequence
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		addr = 4'h0;
		wdata = 36'h0;
		wr = 1'b0;
		rd = 1'b0;
		fails = 0;
		num_checks = 0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		// reset state and an unmapped place
		chk("ic_rst", 36'h0, {21'h0, ic});
		rd_reg(`CTU_A_STAT, rv);
		chk("stat_rst", 36'h0, rv);
		rd_reg(`CTU_A_AR, rv);
		chk("ar_rst", 36'h0, rv);
		rd_reg(4'h6, rv);
		chk("unmapped", 36'h0, rv);
		// index register contents
		wr_reg(`CTU_A_XR0, 36'h0);
		wr_reg(4'h9, 36'h5);
		wr_reg(4'ha, 36'h7fff);
		wr_reg(4'hb, 36'ha);
		wr_reg(4'hc, 36'h10);
		// compare only, boundaries around index values 5 and 7fff
		do_case(`CTU_OP_XGT, 15'h4, 3'h1, 3'h0, 1, 0, BA, 0);
		do_case(`CTU_OP_XGT, 15'h5, 3'h1, 3'h0, 0, 0, BA, 0);
		// equal values leave the compare flag set
		rd_reg(`CTU_A_STAT, rv);
		chk("xc", 36'h8, {32'h0, rv[3:0]});
		do_case(`CTU_OP_XLE, 15'h5, 3'h1, 3'h0, 1, 0, BA, 0);
		do_case(`CTU_OP_XLE, 15'h4, 3'h1, 3'h0, 0, 0, BA, 0);
		do_case(`CTU_OP_XGT, 15'h0, 3'h2, 3'h0, 1, 0, BA, 0);
		do_case(`CTU_OP_XLE, 15'h7fff, 3'h2, 3'h0, 1, 0, BA, 0);
		// compare and reduce, index 3 starts at 10
		do_case(`CTU_OP_MGT, 15'h3, 3'h3, 3'h0, 1, 0, BA, 0);
		do_case(`CTU_OP_XLE, 15'h7, 3'h3, 3'h0, 1, 0, BA, 0);
		do_case(`CTU_OP_XGT, 15'h6, 3'h3, 3'h0, 1, 0, BA, 0);
		do_case(`CTU_OP_MGT, 15'h7, 3'h3, 3'h0, 0, 0, BA, 0);
		do_case(`CTU_OP_MLE, 15'h8, 3'h3, 3'h0, 1, 0, BA, 0);
		do_case(`CTU_OP_MLE, 15'h2, 3'h3, 3'h0, 0, 0, BA, 0);
		do_case(`CTU_OP_XLE, 15'h5, 3'h3, 3'h0, 1, 0, BA, 0);
		do_case(`CTU_OP_XGT, 15'h4, 3'h3, 3'h0, 1, 0, BA, 0);
		// counter write while busy is ignored
		do_case(`CTU_OP_XGT, 15'h4, 3'h1, 3'h0, 1, 0, BA, 1);
		// accumulator negative with zero magnitude
		wr_reg(`CTU_A_ACC, 36'h8_0000_0000);
		do_case(`CTU_OP_AMI, 15'h0, 3'h0, 3'h0, 1, 0, BA, 0);
		do_case(`CTU_OP_APL, 15'h0, 3'h0, 3'h0, 0, 0, BA, 0);
		do_case(`CTU_OP_ANZ, 15'h0, 3'h0, 3'h0, 0, 0, BA, 0);
		do_case(`CTU_OP_AZE, 15'h0, 3'h0, 3'h0, 1, 0, BA, 0);
		// accumulator positive, magnitude one, indexed base
		wr_reg(`CTU_A_ACC, 36'h1);
		do_case(`CTU_OP_AMI, 15'h0, 3'h4, 3'h0, 0, 0, BA + 15'h10, 0);
		do_case(`CTU_OP_APL, 15'h0, 3'h4, 3'h0, 1, 0, BA + 15'h10, 0);
		do_case(`CTU_OP_ANZ, 15'h0, 3'h0, 3'h0, 1, 0, BA, 0);
		do_case(`CTU_OP_AZE, 15'h0, 3'h0, 3'h0, 0, 0, BA, 0);
		// overflow indicator: set, untouched by sign test, then tested
		wr_reg(`CTU_A_CTRL, 36'h4);
		rd_reg(`CTU_A_STAT, rv);
		chk("ovf_set", 36'h4, {33'h0, rv[2:0]});
		do_case(`CTU_OP_AMI, 15'h0, 3'h0, 3'h0, 0, 1, BA, 0);
		do_case(`CTU_OP_AMI, 15'h0, 3'h0, 3'h2, 1, 0, BA, 0);
		do_case(`CTU_OP_AMI, 15'h0, 3'h0, 3'h2, 0, 0, BA, 0);
		// readback of control, instruction and accumulator
		rd_reg(`CTU_A_CTRL, rv);
		chk("ctrl", 36'h2, rv);
		rd_reg(`CTU_A_INSTR, rv);
		chk("instr", {`CTU_OP_AMI, 15'h0, 3'h0, BA}, rv);
		rd_reg(`CTU_A_ACC, rv);
		chk("acc", 36'h1, rv);
		stop_test();
	end
endmodule // testbench
